// [vsl_store_unit.sv]
// Viterbi shift-left store unit with its address and control registers
//
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/10ps
module vsl_store_unit #(
  parameter int unsigned REG_ADDR_W = 7
) (
  // Clock and reset
  input  wire logic                    MCLK,
  input  wire logic                    RESET_N,
  // Register port
  input  wire logic [REG_ADDR_W-1:0]   REG_ADDR,
  input  wire logic [31:0]             REG_WDATA,
  input  wire logic                    REG_WR,
  input  wire logic                    REG_RD,
  output logic      [31:0]             REG_RDATA,
  // Operation issue
  input  wire logic                    OP_VALID,
  input  wire logic [1:0]              OP_FORM,
  input  wire logic                    OP_PREFIX,
  input  wire logic [2:0]              OP_AREG_FIELD,
  // Default source data registers
  input  wire logic [31:0]             SRC_METRIC_A,
  input  wire logic [31:0]             SRC_METRIC_B,
  input  wire logic [31:0]             SRC_CAND_ZERO,
  input  wire logic [31:0]             SRC_CAND_ONE,
  // Upper source data registers
  input  wire logic [31:0]             SRC_HI_METRIC_A,
  input  wire logic [31:0]             SRC_HI_METRIC_B,
  input  wire logic [31:0]             SRC_HI_CAND_ZERO,
  input  wire logic [31:0]             SRC_HI_CAND_ONE,
  // Memory store port
  output logic                         MEM_WR,
  output logic      [31:0]             MEM_ADDR,
  output logic      [63:0]             MEM_WDATA,
  output logic      [3:0]              MEM_HWEN
);

  localparam int unsigned DW = vsl_pkg::DATA_W;
  localparam int unsigned WW = vsl_pkg::WORD_W;
  localparam int unsigned NS = vsl_pkg::NUM_SLOTS;

  if (REG_ADDR_W < vsl_pkg::REG_ADDR_W_MIN) begin : g_bad_width
    $error("REG_ADDR_W too narrow for the register map");
  end

  typedef struct packed {
    logic [vsl_pkg::AREG_NUM-1:0][DW-1:0] areg;
    logic [DW-1:0]                        offset;
    logic [DW-1:0]                        modifier_control_reg;
    logic [DW-1:0]                        status;
    logic [DW-1:0]                        excmod;
    logic [DW-1:0]                        rdata;
    logic                                 mem_wr;
    logic [DW-1:0]                        mem_addr;
    logic [NS-1:0][WW-1:0]                mem_data;
    logic [NS-1:0]                        mem_hwen;
  } vsl_state_s;

  vsl_state_s st_r;
  vsl_state_s st_nxt;

  vsl_pkg::vsl_form_e                 form;
  logic                               is_quad;
  logic                               is_high;
  logic                               big;
  logic [vsl_pkg::AREG_IDX_W-1:0]     op_idx;
  logic [DW-1:0]                      areg_cur;
  logic [DW-1:0]                      areg_sum;
  logic [DW-1:0]                      m_a;
  logic [DW-1:0]                      m_b;
  logic [DW-1:0]                      c0;
  logic [DW-1:0]                      c1;
  logic [WW-1:0]                      h_a;
  logic [WW-1:0]                      h_b;
  logic [WW-1:0]                      hc0;
  logic [WW-1:0]                      hc1;
  logic [1:0]                         pick;
  logic [1:0][WW-1:0]                 sh;
  logic [vsl_pkg::REG_IDX_W-1:0]      reg_idx;
  logic                               reg_hit;

  vsl_place_if pl ();

  // Operation decode
  assign form    = vsl_pkg::vsl_form_e'(OP_FORM);
  assign is_quad = (form == vsl_pkg::VSL_QUAD_LOW) ||
                   (form == vsl_pkg::VSL_QUAD_HIGH);
  assign is_high = (form == vsl_pkg::VSL_QUAD_HIGH) ||
                   (form == vsl_pkg::VSL_PAIR_HIGH);
  assign big     = st_r.excmod[vsl_pkg::EMR_BIG_BIT];
  assign op_idx  = {OP_PREFIX, OP_AREG_FIELD};
  assign areg_cur = st_r.areg[op_idx];
  // Modifier modes other than linear are not modelled here
  assign areg_sum = areg_cur + st_r.offset;

  // Source set selection; sources are only ever read
  assign m_a = OP_PREFIX ? SRC_HI_METRIC_A  : SRC_METRIC_A;
  assign m_b = OP_PREFIX ? SRC_HI_METRIC_B  : SRC_METRIC_B;
  assign c0  = OP_PREFIX ? SRC_HI_CAND_ZERO : SRC_CAND_ZERO;
  assign c1  = OP_PREFIX ? SRC_HI_CAND_ONE  : SRC_CAND_ONE;

  // Half selection
  assign h_a = is_high ? m_a[DW-1:WW] : m_a[WW-1:0];
  assign h_b = is_high ? m_b[DW-1:WW] : m_b[WW-1:0];
  assign hc0 = is_high ? c0[DW-1:WW]  : c0[WW-1:0];
  assign hc1 = is_high ? c1[DW-1:WW]  : c1[WW-1:0];

  // Path flags; zero-fill word uses flag 0 or 1, one-fill uses 2 or 3
  assign pick[0] = is_high ? st_r.status[vsl_pkg::SR_FLAG1_BIT]
                           : st_r.status[vsl_pkg::SR_FLAG0_BIT];
  assign pick[1] = is_high ? st_r.status[vsl_pkg::SR_FLAG3_BIT]
                           : st_r.status[vsl_pkg::SR_FLAG2_BIT];

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_shift
      vsl_shift_pick u_pick (
        .cand_zero (hc0),
        .cand_one  (hc1),
        .pick_one  (pick[g]),
        .fill      ((g == 0) ? vsl_pkg::FILL_ZERO : vsl_pkg::FILL_ONE),
        .shifted   (sh[g])
      );
    end
  endgenerate

  // Word assembly: quad has metrics first, pair only the shifted words
  always_comb begin
    if (is_quad) begin
      pl.word = {sh[1], sh[0], h_b, h_a};
    end else begin
      pl.word = {{WW{1'b0}}, {WW{1'b0}}, sh[1], sh[0]};
    end
  end
  assign pl.quad    = is_quad;
  assign pl.big     = big;
  // Quad ignores the pair bit; a misaligned base is software's fault
  assign pl.slot_hi = areg_cur[vsl_pkg::PAIR_BIT];

  vsl_slot_place u_place (
    .pl (pl)
  );

  // Register decode
  assign reg_idx = REG_ADDR[vsl_pkg::REG_IDX_LSB +: vsl_pkg::REG_IDX_W];
  // Shift, not part-select: at the minimum width nothing lies above
  assign reg_hit = (REG_ADDR[vsl_pkg::REG_IDX_LSB-1:0] == 2'h0) &&
                   ((REG_ADDR >> (vsl_pkg::REG_IDX_LSB +
                                  vsl_pkg::REG_IDX_W)) == '0);

  always_comb begin
    st_nxt = st_r;
    st_nxt.rdata  = '0;
    st_nxt.mem_wr = 1'b0;
    // Software writes first so an operation's post-update wins
    if (REG_WR && reg_hit) begin
      if (reg_idx < vsl_pkg::REG_IDX_W'(vsl_pkg::AREG_NUM)) begin
        st_nxt.areg[reg_idx[vsl_pkg::AREG_IDX_W-1:0]] = REG_WDATA;
      end else begin
        unique case (reg_idx)
          vsl_pkg::REG_IDX_OFFSET: st_nxt.offset = REG_WDATA;
          vsl_pkg::REG_IDX_MODIFIER_CONTROL_REG:   st_nxt.modifier_control_reg   = REG_WDATA;
          vsl_pkg::REG_IDX_STATUS: st_nxt.status = REG_WDATA;
          vsl_pkg::REG_IDX_EXCMOD: st_nxt.excmod = REG_WDATA;
          default:                 st_nxt.offset = st_r.offset;
        endcase
      end
    end
    // Unmapped reads answer zero
    if (REG_RD && reg_hit) begin
      if (reg_idx < vsl_pkg::REG_IDX_W'(vsl_pkg::AREG_NUM)) begin
        st_nxt.rdata = st_r.areg[reg_idx[vsl_pkg::AREG_IDX_W-1:0]];
      end else begin
        unique case (reg_idx)
          vsl_pkg::REG_IDX_OFFSET: st_nxt.rdata = st_r.offset;
          vsl_pkg::REG_IDX_MODIFIER_CONTROL_REG:   st_nxt.rdata = st_r.modifier_control_reg;
          vsl_pkg::REG_IDX_STATUS: st_nxt.rdata = st_r.status;
          vsl_pkg::REG_IDX_EXCMOD: st_nxt.rdata = st_r.excmod;
          default:                 st_nxt.rdata = '0;
        endcase
      end
    end
    if (OP_VALID) begin
      st_nxt.mem_wr   = 1'b1;
      st_nxt.mem_addr = {areg_cur[DW-1:vsl_pkg::ALIGN_LSBS],
                         {vsl_pkg::ALIGN_LSBS{1'b0}}};
      st_nxt.mem_data = pl.slot_data;
      st_nxt.mem_hwen = pl.slot_en;
      st_nxt.areg[op_idx] = areg_sum;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      st_r <= '0;
      st_r.offset <= vsl_pkg::REG_RESET;
      st_r.status <= vsl_pkg::REG_RESET;
      st_r.excmod <= vsl_pkg::REG_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign REG_RDATA = st_r.rdata;
  assign MEM_WR    = st_r.mem_wr;
  assign MEM_ADDR  = st_r.mem_addr;
  assign MEM_WDATA = st_r.mem_data;
  assign MEM_HWEN  = st_r.mem_hwen;

  // Checks
  chk_quad_low_order: assert property (
    @(posedge MCLK) disable iff (!RESET_N)
    OP_VALID && form == vsl_pkg::VSL_QUAD_LOW && !big |=>
      MEM_WR && st_r.mem_data[0] == $past(m_a[WW-1:0]) &&
      st_r.mem_data[1] == $past(m_b[WW-1:0]))
    else $error("quad low metric words misplaced");

  chk_fill_bits: assert property (
    @(posedge MCLK) disable iff (!RESET_N)
    OP_VALID && is_quad && !big |=>
      st_r.mem_data[2][0] == vsl_pkg::FILL_ZERO &&
      st_r.mem_data[3][0] == vsl_pkg::FILL_ONE)
    else $error("shift fill bit wrong");

  chk_word2_pick: assert property (
    @(posedge MCLK) disable iff (!RESET_N)
    OP_VALID && form == vsl_pkg::VSL_QUAD_LOW && !big |=>
      st_r.mem_data[2][WW-1:1] == ($past(st_r.status[vsl_pkg::SR_FLAG0_BIT]) ?
        $past(hc1[WW-2:0]) : $past(hc0[WW-2:0])))
    else $error("quad low word 2 picked wrong candidate");

  chk_word3_pick: assert property (
    @(posedge MCLK) disable iff (!RESET_N)
    OP_VALID && form == vsl_pkg::VSL_QUAD_LOW && !big |=>
      st_r.mem_data[3][WW-1:1] == ($past(st_r.status[vsl_pkg::SR_FLAG2_BIT]) ?
        $past(hc1[WW-2:0]) : $past(hc0[WW-2:0])))
    else $error("quad low word 3 picked wrong candidate");

  chk_high_halves: assert property (
    @(posedge MCLK) disable iff (!RESET_N)
    OP_VALID && form == vsl_pkg::VSL_QUAD_HIGH && !big |=>
      st_r.mem_data[0] == $past(m_a[DW-1:WW]) &&
      st_r.mem_data[3][WW-1:1] == ($past(st_r.status[vsl_pkg::SR_FLAG3_BIT]) ?
        $past(c1[DW-2:WW]) : $past(c0[DW-2:WW])))
    else $error("quad high word wrong");

  chk_pair_low: assert property (
    @(posedge MCLK) disable iff (!RESET_N)
    OP_VALID && form == vsl_pkg::VSL_PAIR_LOW && !big &&
    !areg_cur[vsl_pkg::PAIR_BIT] |=>
      MEM_HWEN == 4'h3 && st_r.mem_data[1][0] == vsl_pkg::FILL_ONE &&
      st_r.mem_data[0][WW-1:1] == ($past(st_r.status[vsl_pkg::SR_FLAG0_BIT]) ?
        $past(c1[WW-2:0]) : $past(c0[WW-2:0])))
    else $error("pair low store wrong");

  chk_pair_high: assert property (
    @(posedge MCLK) disable iff (!RESET_N)
    OP_VALID && form == vsl_pkg::VSL_PAIR_HIGH && !big &&
    areg_cur[vsl_pkg::PAIR_BIT] |=>
      MEM_HWEN == 4'hc &&
      st_r.mem_data[3][WW-1:1] == ($past(st_r.status[vsl_pkg::SR_FLAG3_BIT]) ?
        $past(c1[DW-2:WW]) : $past(c0[DW-2:WW])))
    else $error("pair high store wrong");

  chk_big_swap: assert property (
    @(posedge MCLK) disable iff (!RESET_N)
    OP_VALID && form == vsl_pkg::VSL_QUAD_LOW &&
    st_r.excmod[vsl_pkg::EMR_BIG_BIT] |=>
      st_r.mem_data[1] == $past(m_a[WW-1:0]) &&
      st_r.mem_data[0] == $past(m_b[WW-1:0]) &&
      st_r.mem_data[3][0] == vsl_pkg::FILL_ZERO)
    else $error("big endian word order wrong");

  chk_post_update: assert property (
    @(posedge MCLK) disable iff (!RESET_N)
    OP_VALID |=> st_r.areg[$past(op_idx)] == $past(areg_sum))
    else $error("address register not post-updated");

  chk_one_store: assert property (
    @(posedge MCLK) disable iff (!RESET_N)
    MEM_WR |-> $past(OP_VALID) && MEM_ADDR[2:0] == 3'h0 &&
      MEM_HWEN != 4'h0)
    else $error("store not single aligned pulse");

  chk_quad_high_rest: assert property (
    @(posedge MCLK) disable iff (!RESET_N)
    OP_VALID && form == vsl_pkg::VSL_QUAD_HIGH && !big |=>
      st_r.mem_data[1] == $past(m_b[DW-1:WW]) &&
      st_r.mem_data[2] ==
        {($past(st_r.status[vsl_pkg::SR_FLAG1_BIT]) ? $past(c1[DW-2:WW]) :
          $past(c0[DW-2:WW])), vsl_pkg::FILL_ZERO})
    else $error("quad high words 1 or 2 wrong");

  chk_flag_source: assert property (
    @(posedge MCLK) disable iff (!RESET_N)
    OP_VALID && form == vsl_pkg::VSL_PAIR_LOW && !big &&
    !areg_cur[vsl_pkg::PAIR_BIT] && c0[WW-2:0] != c1[WW-2:0] |=>
      (st_r.mem_data[1][WW-1:1] == $past(c1[WW-2:0])) ==
        $past(st_r.status[vsl_pkg::SR_FLAG2_BIT]))
    else $error("path flag 2 not taken from its status bit");

  chk_pair_big: assert property (
    @(posedge MCLK) disable iff (!RESET_N)
    OP_VALID && form == vsl_pkg::VSL_PAIR_HIGH && big &&
    !areg_cur[vsl_pkg::PAIR_BIT] |=>
      MEM_HWEN == 4'h3 && st_r.mem_data[0][0] == vsl_pkg::FILL_ONE &&
      st_r.mem_data[1][0] == vsl_pkg::FILL_ZERO)
    else $error("big endian pair order wrong");

  chk_ctrl_untouched: assert property (
    @(posedge MCLK) disable iff (!RESET_N)
    OP_VALID && !REG_WR |=>
      $stable(st_r.offset) && $stable(st_r.modifier_control_reg) &&
      $stable(st_r.status) && $stable(st_r.excmod))
    else $error("operation changed a control register");

  chk_upper_sources: assert property (
    @(posedge MCLK) disable iff (!RESET_N)
    OP_VALID && OP_PREFIX && form == vsl_pkg::VSL_QUAD_LOW && !big |=>
      st_r.mem_data[0] == $past(SRC_HI_METRIC_A[WW-1:0]) &&
      st_r.mem_data[1] == $past(SRC_HI_METRIC_B[WW-1:0]))
    else $error("prefix did not pick upper metric set");

  chk_quad_enables: assert property (
    @(posedge MCLK) disable iff (!RESET_N)
    OP_VALID && is_quad |=> MEM_WR && MEM_HWEN == 4'hf)
    else $error("quad store must enable all halfwords");

  chk_prefix_index: assert property (
    @(posedge MCLK) disable iff (!RESET_N)
    OP_VALID && OP_PREFIX |=>
      MEM_ADDR[DW-1:vsl_pkg::ALIGN_LSBS] ==
        $past(st_r.areg[{1'b1, OP_AREG_FIELD}][DW-1:vsl_pkg::ALIGN_LSBS]))
    else $error("prefix did not select an upper address register");

endmodule

// [vsl_pkg.sv]
// Shared constants and types of the Viterbi shift store unit
package vsl_pkg;

  // Store forms carried on the operation port
  typedef enum logic [1:0] {
    VSL_QUAD_LOW  = 2'h0,
    VSL_QUAD_HIGH = 2'h1,
    VSL_PAIR_LOW  = 2'h2,
    VSL_PAIR_HIGH = 2'h3
  } vsl_form_e;

  // Datapath geometry
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned WORD_W     = 16;
  localparam int unsigned NUM_SLOTS  = 4;
  localparam int unsigned SLOT_IDX_W = 2;
  localparam int unsigned AREG_NUM   = 16;
  localparam int unsigned AREG_IDX_W = 4;
  localparam int unsigned ALIGN_LSBS = 3;
  localparam int unsigned PAIR_BIT   = 2;

  // Register port decode
  localparam int unsigned REG_ADDR_W_MIN = 7;
  localparam int unsigned REG_IDX_LSB    = 2;
  localparam int unsigned REG_IDX_W      = 5;
  localparam logic [REG_IDX_W-1:0] REG_IDX_OFFSET = 5'h10;
  localparam logic [REG_IDX_W-1:0] REG_IDX_MODIFIER_CONTROL_REG   = 5'h11;
  localparam logic [REG_IDX_W-1:0] REG_IDX_STATUS = 5'h12;
  localparam logic [REG_IDX_W-1:0] REG_IDX_EXCMOD = 5'h13;

  // Field positions
  localparam int unsigned SR_FLAG0_BIT = 8;
  localparam int unsigned SR_FLAG1_BIT = 9;
  localparam int unsigned SR_FLAG2_BIT = 10;
  localparam int unsigned SR_FLAG3_BIT = 11;
  localparam int unsigned EMR_BIG_BIT  = 16;

  // Reset and fill values
  localparam logic [DATA_W-1:0] REG_RESET = 32'h0;
  localparam logic              FILL_ZERO = 1'b0;
  localparam logic              FILL_ONE  = 1'b1;

endpackage

// [vsl_place_if.sv]
// Word-to-slot placement bundle between the store unit and its placer
`timescale 1ns/10ps
interface vsl_place_if;
  logic [vsl_pkg::NUM_SLOTS-1:0][vsl_pkg::WORD_W-1:0] word;
  logic                                               quad;
  logic                                               big;
  logic                                               slot_hi;
  logic [vsl_pkg::NUM_SLOTS-1:0][vsl_pkg::WORD_W-1:0] slot_data;
  logic [vsl_pkg::NUM_SLOTS-1:0]                      slot_en;

  modport feed  (output word, quad, big, slot_hi,
                 input  slot_data, slot_en);
  modport place (input  word, quad, big, slot_hi,
                 output slot_data, slot_en);
endinterface

// [vsl_shift_pick.sv]
// Candidate select and one-bit left shift with programmable fill
`timescale 1ns/10ps
module vsl_shift_pick (
  // Candidate halves
  input  wire logic [vsl_pkg::WORD_W-1:0] cand_zero,
  input  wire logic [vsl_pkg::WORD_W-1:0] cand_one,
  // Control
  input  wire logic                       pick_one,
  input  wire logic                       fill,
  // Result
  output logic      [vsl_pkg::WORD_W-1:0] shifted
);

  logic [vsl_pkg::WORD_W-1:0] picked;

  always_comb begin
    picked  = pick_one ? cand_one : cand_zero;
    shifted = {picked[vsl_pkg::WORD_W-2:0], fill};
  end

endmodule

// [vsl_slot_place.sv]
// Maps store words onto halfword slots of one aligned memory line
`timescale 1ns/10ps
module vsl_slot_place (
  // Placement bundle
  vsl_place_if.place pl
);

  genvar s;
  generate
    for (s = 0; s < vsl_pkg::NUM_SLOTS; s++) begin : g_slot
      localparam logic [vsl_pkg::SLOT_IDX_W-1:0] SLOT =
        vsl_pkg::SLOT_IDX_W'(s);
      logic [vsl_pkg::SLOT_IDX_W-1:0] base;
      logic [vsl_pkg::SLOT_IDX_W-1:0] rel;
      logic [vsl_pkg::SLOT_IDX_W-1:0] widx;
      // A pair sits in the lower or upper half of the line
      assign base = pl.quad ? 2'h0 : {pl.slot_hi, 1'b0};
      assign rel  = SLOT - base;
      // Big endian swaps the two words of each long word
      assign widx = pl.big ? (rel ^ 2'h1) : rel;
      assign pl.slot_data[s] = pl.word[widx];
      assign pl.slot_en[s]   = pl.quad | (SLOT[1] == pl.slot_hi);
    end
  endgenerate

endmodule

// [vsl_mem_model.sv]
// Behavioural data memory that records halfword stores
`timescale 1ns/10ps
module vsl_mem_model (
  // Clock
  input wire logic        clk,
  // Store port
  input wire logic        wr,
  input wire logic [31:0] addr,
  input wire logic [63:0] wdata,
  input wire logic [3:0]  hwen
);
  logic [15:0] mem [logic [31:0]];

  // Disabled lanes carry junk, so only enabled halfwords land
  always @(posedge clk) begin
    if (wr) begin
      for (int s = 0; s < 4; s++) begin
        if (hwen[s]) begin
          mem[addr + 32'(2 * s)] = wdata[16*s +: 16];
        end
      end
    end
  end
endmodule

// [vsl_store_unit_bench.sv]
// Self-checking bench for the Viterbi shift store unit
`timescale 1ns/10ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin failures++; \
  $display("unexpected at %0t: got %h expected %h", $time, (a), (e)); end end
module vsl_store_unit_bench;
  logic        MCLK = 1'b0;
  logic        RESET_N = 1'b0;
  logic [6:0]  REG_ADDR = 7'h0;
  logic [31:0] REG_WDATA = 32'h0;
  logic        REG_WR = 1'b0;
  logic        REG_RD = 1'b0;
  logic [31:0] REG_RDATA;
  logic        OP_VALID = 1'b0;
  logic [1:0]  OP_FORM = 2'h0;
  logic        OP_PREFIX = 1'b0;
  logic [2:0]  OP_AREG_FIELD = 3'h0;
  logic [31:0] ma = 32'ha1b2c3d4, mb = 32'h55667788;
  logic [31:0] cz = 32'h2a62ea79, co = 32'h54379eac;
  logic [31:0] hma = 32'h0f1e2d3c, hmb = 32'h99aabbcc;
  logic [31:0] hcz = 32'h80017ffe, hco = 32'hc3c33c3c;
  logic        MEM_WR;
  logic [31:0] MEM_ADDR;
  logic [63:0] MEM_WDATA;
  logic [3:0]  MEM_HWEN;
  int          failures = 0;
  int          tests_run = 0;

  always #50 MCLK = ~MCLK;

  vsl_store_unit u_dut (.MCLK(MCLK), .RESET_N(RESET_N),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .OP_VALID(OP_VALID),
    .OP_FORM(OP_FORM), .OP_PREFIX(OP_PREFIX),
    .OP_AREG_FIELD(OP_AREG_FIELD), .SRC_METRIC_A(ma), .SRC_METRIC_B(mb),
    .SRC_CAND_ZERO(cz), .SRC_CAND_ONE(co), .SRC_HI_METRIC_A(hma),
    .SRC_HI_METRIC_B(hmb), .SRC_HI_CAND_ZERO(hcz), .SRC_HI_CAND_ONE(hco),
    .MEM_WR(MEM_WR), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA),
    .MEM_HWEN(MEM_HWEN));

  vsl_mem_model u_mem (.clk(MCLK), .wr(MEM_WR), .addr(MEM_ADDR),
    .wdata(MEM_WDATA), .hwen(MEM_HWEN));

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    @(posedge MCLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge MCLK);
    REG_WR <= 1'b0;
  endtask

  task automatic rd(input logic [6:0] a, output logic [31:0] d);
    @(posedge MCLK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge MCLK);
    REG_RD <= 1'b0;
    #1 d = REG_RDATA;
  endtask

  // Holding the strobe n cycles issues n operations back to back
  task automatic op(input logic [1:0] f, input logic p,
                    input logic [2:0] r, input int n);
    @(posedge MCLK);
    OP_VALID <= 1'b1;
    OP_FORM <= f;
    OP_PREFIX <= p;
    OP_AREG_FIELD <= r;
    repeat (n) @(posedge MCLK);
    OP_VALID <= 1'b0;
    #1 `CHK(MEM_WR, 1'b1)
    @(posedge MCLK);
    #1 `CHK(MEM_WR, 1'b0)
  endtask

  function automatic logic [15:0] half(logic [31:0] x, logic hi);
    return hi ? x[31:16] : x[15:0];
  endfunction

  function automatic logic [15:0] shl(logic [15:0] z, logic [15:0] o,
                                      logic p, logic fill);
    logic [15:0] c;
    c = p ? o : z;
    return {c[14:0], fill};
  endfunction

  initial begin : main
    logic [31:0] d, base, off, a;
    logic [15:0] w [4];
    logic [3:0]  fl;
    logic [3:0]  idx;
    logic [1:0]  f;
    logic        big, pre, pz, po;
    repeat (8) @(posedge MCLK);
    RESET_N <= 1'b1;
    rd(7'h48, d);
    `CHK(d, 32'h0)
    wr(7'h48, 32'h00e40f00);
    rd(7'h48, d);
    `CHK(d, 32'h00e40f00)
    // Modifier control is storage only; the loop below keeps it nonzero
    wr(7'h44, 32'h0000000c);
    rd(7'h44, d);
    `CHK(d, 32'h0000000c)
    wr(7'h50, 32'hffffffff);
    rd(7'h50, d);
    `CHK(d, 32'h0)
    rd(7'h42, d);
    `CHK(d, 32'h0)
    $display("test registers done");
    // Worked example, pair low form in both endian modes
    for (int b = 0; b < 2; b++) begin
      wr(7'h00, 32'h60 + 32'(b * 16));
      wr(7'h40, 32'h8);
      wr(7'h48, 32'h00e40000);
      wr(7'h4c, b ? 32'h00010000 : 32'h0);
      op(2'h2, 1'b0, 3'h0, 1);
      a = 32'h60 + 32'(b * 16);
      `CHK(u_mem.mem[a], b ? 16'hd4f3 : 16'hd4f2)
      `CHK(u_mem.mem[a + 2], b ? 16'hd4f2 : 16'hd4f3)
      rd(7'h00, d);
      `CHK(d, a + 32'h8)
    end
    $display("test example done");
    for (int i = 0; i < 64; i++) begin
      f = i[1:0];
      fl = i[5:2];
      big = i[2] ^ i[5];
      pre = i[3];
      idx = {pre, i[5:3] ^ i[2:0]};
      // Quad bases stay 8-aligned, pair bases 4-aligned
      base = 32'h1000 + 32'(i * 16) +
             ((f[1] & i[4]) ? 32'h4 : 32'h0);
      off = 32'h10 + 32'(i);
      wr({1'b0, idx, 2'b00}, base);
      wr(7'h40, off);
      wr(7'h48, {20'h00e40, fl, 8'h00});
      wr(7'h4c, {15'h7fff, big, 16'h0005});
      op(f, pre, idx[2:0], 1);
      pz = f[0] ? fl[1] : fl[0];
      po = f[0] ? fl[3] : fl[2];
      w[2] = shl(half(pre ? hcz : cz, f[0]), half(pre ? hco : co, f[0]),
                 pz, 1'b0);
      w[3] = shl(half(pre ? hcz : cz, f[0]), half(pre ? hco : co, f[0]),
                 po, 1'b1);
      w[0] = f[1] ? w[2] : half(pre ? hma : ma, f[0]);
      w[1] = f[1] ? w[3] : half(pre ? hmb : mb, f[0]);
      `CHK(MEM_ADDR, {base[31:3], 3'h0})
      `CHK(MEM_HWEN, f[1] ? (base[2] ? 4'hc : 4'h3) : 4'hf)
      for (int k = 0; k < (f[1] ? 2 : 4); k++) begin
        a = base + 32'(2 * (big ? (k ^ 1) : k));
        if (f == 2'h0 && k < 2) `CHK(u_mem.mem[a], w[k])
        else if (f == 2'h0 && k == 2) `CHK(u_mem.mem[a], w[k])
        else if (f == 2'h0) `CHK(u_mem.mem[a], w[k])
        else if (f == 2'h1) `CHK(u_mem.mem[a], w[k])
        else if (f == 2'h2) `CHK(u_mem.mem[a], w[k])
        else `CHK(u_mem.mem[a], w[k])
      end
      rd({1'b0, idx, 2'b00}, d);
      `CHK(d, base + off)
    end
    $display("test forms done");
    // Second operation must see the first one's updated address
    wr(7'h04, 32'h200);
    wr(7'h40, 32'h4);
    op(2'h2, 1'b0, 3'h1, 2);
    `CHK(MEM_ADDR, 32'h200)
    `CHK(MEM_HWEN, 4'hc)
    rd(7'h04, d);
    `CHK(d, 32'h208)
    $display("test back to back done");
    test_done();
  end

  initial begin : watchdog
    repeat (20000) @(posedge MCLK);
    failures++;
    test_done();
  end
endmodule
